//--- verilog/bcr_correlator.sv
// 64-bit serial binary correlator with threshold flag and wishbone status
//
// The Wishbone register port and the address map were left to the implementer.
`timescale 1ns/10ps
module bcr_correlator (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic sample_din_i,
	input wire logic template_din_i,
	input wire logic mask_din_i,
	input wire logic sample_clk_i,
	input wire logic template_clk_i,
	input wire logic mask_clk_i,
	input wire logic threshold_clk_i,
	input wire logic summer_clk_i,
	input wire logic reference_load_ctrl_i,
	input wire logic output_hiz_ctrl_i,
	input wire logic output_invert_ctrl_i,
	input wire logic [6:0] score_bus_i,
	output logic [6:0] score_bus_o,
	output logic score_bus_oe_n_o,
	output logic threshold_hit_flag_o,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	localparam int N = bcr_pkg::REG_W;

	// count of ones in one 8-bit slice
	function automatic logic [3:0] part_count(input logic [7:0] v);
		logic [3:0] c;
		c = 4'h0;
		for (int i = 0; i < 8; i++) begin
			c = c + {3'h0, v[i]};
		end
		return c;
	endfunction : part_count

	// sum of the eight partial counts
	function automatic logic [6:0] part_total(input logic [31:0] p);
		logic [6:0] s;
		s = 7'h00;
		for (int i = 0; i < bcr_pkg::PART_N; i++) begin
			s = s + {3'h0, p[i*4 +: 4]};
		end
		return s;
	endfunction : part_total

	logic [17:0] pin_lvl;
	logic [17:0] pin_rise;

	// every pin crosses two flops before use
	bcr_pin_sync #(
		.WIDTH(bcr_pkg::SYNC_W)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i({score_bus_i, output_invert_ctrl_i, output_hiz_ctrl_i,
			reference_load_ctrl_i, summer_clk_i, threshold_clk_i, mask_clk_i,
			template_clk_i, sample_clk_i, mask_din_i, template_din_i, sample_din_i}),
		.level_o(pin_lvl),
		.rise_o(pin_rise)
	);

	logic sample_bit;
	logic template_bit;
	logic mask_bit;
	logic sample_rise;
	logic template_rise;
	logic mask_rise;
	logic thr_rise;
	logic sum_rise;
	logic sum_lvl;
	logic ref_load_pin;
	logic hiz_lvl;
	logic inv_pin;
	logic [6:0] bus_lvl;

	assign sample_bit = pin_lvl[0];
	assign template_bit = pin_lvl[1];
	assign mask_bit = pin_lvl[2];
	assign sample_rise = pin_rise[3];
	assign template_rise = pin_rise[4];
	assign mask_rise = pin_rise[5];
	assign thr_rise = pin_rise[6];
	assign sum_rise = pin_rise[7];
	assign sum_lvl = pin_lvl[7];
	assign ref_load_pin = pin_lvl[8];
	assign hiz_lvl = pin_lvl[9];
	assign inv_pin = pin_lvl[10];
	assign bus_lvl = pin_lvl[17:11];

	// shift registers and reference latch
	logic [N-1:0] sample_reg, sample_next;
	logic [N-1:0] template_reg, template_next;
	logic [N-1:0] mask_reg, mask_next;
	logic [N-1:0] ref_reg, ref_next;
	logic ctrl_ref_reg, ctrl_ref_next;
	logic ref_load_eff;

	assign ref_load_eff = ref_load_pin | ctrl_ref_reg;

	// shifting and reference tracking
	always_comb begin
		sample_next = sample_reg;
		template_next = template_reg;
		mask_next = mask_reg;
		ref_next = ref_reg;
		if (sample_rise) begin
			sample_next = {sample_reg[N-2:0], sample_bit};
		end
		if (template_rise) begin
			template_next = {template_reg[N-2:0], template_bit};
		end
		if (mask_rise) begin
			mask_next = {mask_reg[N-2:0], mask_bit};
		end
		if (ref_load_eff) begin
			ref_next = template_reg;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sample_reg <= bcr_pkg::VEC_RST;
			template_reg <= bcr_pkg::VEC_RST;
			mask_reg <= bcr_pkg::VEC_RST;
			ref_reg <= bcr_pkg::VEC_RST;
		end else begin
			sample_reg <= sample_next;
			template_reg <= template_next;
			mask_reg <= mask_next;
			ref_reg <= ref_next;
		end
	end

	// summer pipeline with threshold carried alongside
	logic [N-1:0] cmp_vec;
	logic [N-1:0] cmp_reg, cmp_next;
	logic [31:0] part_reg, part_next;
	logic [6:0] score_reg, score_next;
	logic [6:0] thr_reg, thr_next;
	logic [6:0] thr_p1_reg, thr_p1_next;
	logic [6:0] thr_p2_reg, thr_p2_next;
	logic [6:0] thr_p3_reg, thr_p3_next;
	logic flag_reg, flag_next;

	assign cmp_vec = ~(sample_reg ^ ref_reg) & mask_reg;

	always_comb begin
		cmp_next = cmp_reg;
		part_next = part_reg;
		score_next = score_reg;
		thr_next = thr_reg;
		thr_p1_next = thr_p1_reg;
		thr_p2_next = thr_p2_reg;
		thr_p3_next = thr_p3_reg;
		flag_next = flag_reg;
		if (thr_rise) begin
			thr_next = bus_lvl;
		end
		if (sum_rise) begin
			cmp_next = cmp_vec;
			for (int k = 0; k < bcr_pkg::PART_N; k++) begin
				part_next[k*4 +: 4] = part_count(cmp_reg[k*8 +: 8]);
			end
			score_next = part_total(part_reg);
			thr_p1_next = thr_reg;
			thr_p2_next = thr_p1_reg;
			thr_p3_next = thr_p2_reg;
			flag_next = (part_total(part_reg) >= thr_p2_reg);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmp_reg <= bcr_pkg::VEC_RST;
			part_reg <= '0;
			score_reg <= bcr_pkg::SCORE_RST;
			thr_reg <= bcr_pkg::THR_RST;
			thr_p1_reg <= bcr_pkg::THR_RST;
			thr_p2_reg <= bcr_pkg::THR_RST;
			thr_p3_reg <= bcr_pkg::THR_RST;
			flag_reg <= bcr_pkg::FLAG_RST;
		end else begin
			cmp_reg <= cmp_next;
			part_reg <= part_next;
			score_reg <= score_next;
			thr_reg <= thr_next;
			thr_p1_reg <= thr_p1_next;
			thr_p2_reg <= thr_p2_next;
			thr_p3_reg <= thr_p3_next;
			flag_reg <= flag_next;
		end
	end

	// output stage: invert latch open while summer clock is high
	logic inv_eff_reg, inv_eff_next;
	logic [6:0] out_reg, out_next;

	always_comb begin
		inv_eff_next = sum_lvl ? inv_pin : inv_eff_reg;
		out_next = score_reg ^ {7{inv_eff_next}};
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			inv_eff_reg <= 1'b0;
			out_reg <= bcr_pkg::SCORE_RST;
		end else begin
			inv_eff_reg <= inv_eff_next;
			out_reg <= out_next;
		end
	end

	assign score_bus_o = out_reg;
	assign score_bus_oe_n_o = hiz_lvl;
	assign threshold_hit_flag_o = flag_reg;

	// wishbone classic slave, one registered answer per request, acked one clock after it
	logic ack_reg, ack_next;
	logic [31:0] rdat_reg, rdat_next;
	logic req;

	assign req = wb_cyc_i & wb_stb_i & ~ack_reg;

	always_comb begin
		ack_next = req;
		rdat_next = rdat_reg;
		ctrl_ref_next = ctrl_ref_reg;
		if (req) begin
			rdat_next = 32'h0;
			if (wb_adr_i == bcr_pkg::CTRL_OFS) begin
				rdat_next[bcr_pkg::CTRL_REF_LOAD_BIT] = ctrl_ref_reg;
				if (wb_we_i && wb_sel_i[0]) begin
					ctrl_ref_next = wb_dat_i[bcr_pkg::CTRL_REF_LOAD_BIT];
				end
			end else if (wb_adr_i == bcr_pkg::STATUS_OFS) begin
				rdat_next[6:0] = score_reg;
				rdat_next[bcr_pkg::STAT_THR_LSB +: 7] = thr_reg;
				rdat_next[bcr_pkg::STAT_FLAG_BIT] = flag_reg;
				rdat_next[bcr_pkg::STAT_INV_BIT] = inv_eff_reg;
				rdat_next[bcr_pkg::STAT_HIZ_BIT] = hiz_lvl;
			end else if (wb_adr_i == bcr_pkg::REF_LO_OFS) begin
				rdat_next = ref_reg[31:0];
			end else if (wb_adr_i == bcr_pkg::REF_HI_OFS) begin
				rdat_next = ref_reg[63:32];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			rdat_reg <= 32'h0;
			ctrl_ref_reg <= bcr_pkg::CTRL_RST;
		end else begin
			ack_reg <= ack_next;
			rdat_reg <= rdat_next;
			ctrl_ref_reg <= ctrl_ref_next;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;

	// checks on the datapath
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_sum_edge;
		sum_rise;
	endsequence

	a_sample_shift: assert property (
		sample_rise |=> sample_reg == {$past(sample_reg[N-2:0]), $past(sample_bit)})
		else $error("sample register did not shift");
	a_ref_track: assert property (
		ref_load_eff |=> ref_reg == $past(template_reg))
		else $error("reference did not follow template");
	a_ref_hold: assert property (
		!ref_load_eff |=> $stable(ref_reg))
		else $error("reference changed while load low");
	a_cmp_capture: assert property (
		s_sum_edge |=> cmp_reg == $past(cmp_vec))
		else $error("comparison not captured");
	a_mask_zero: assert property (
		s_sum_edge |=> (cmp_reg & ~$past(mask_reg)) == 64'h0)
		else $error("masked bit reached summer");
	a_sum_count: assert property (
		s_sum_edge ##1 (!sum_rise [*1]) |-> part_total(part_reg) == $countones($past(cmp_reg, 2)))
		else $error("partial sums wrong");
	a_flag_cmp: assert property (
		flag_reg == (score_reg >= thr_p3_reg))
		else $error("flag disagrees with score and threshold");
	a_thr_load: assert property (
		thr_rise |=> thr_reg == $past(bus_lvl))
		else $error("threshold not loaded");
	a_hiz_out: assert property (
		score_bus_oe_n_o == $past(output_hiz_ctrl_i, 2))
		else $error("output enable wrong");
	a_inv_form: assert property (
		##1 score_bus_o == ($past(score_reg) ^ {7{inv_eff_reg}}))
		else $error("output form wrong");
	a_inv_hold: assert property (
		!sum_lvl |=> inv_eff_reg == $past(inv_eff_reg))
		else $error("invert changed while clock low");
endmodule : bcr_correlator

//--- verilog/bcr_pkg.sv
// constants shared by the binary correlator design
package bcr_pkg;
	localparam int REG_W = 64;
	localparam int SCORE_W = 7;
	localparam int PART_N = 8;
	localparam int PART_W = 4;
	localparam int ADR_W = 4;
	localparam int SYNC_W = 18;
	// register byte offsets
	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [3:0] STATUS_OFS = 4'h4;
	localparam logic [3:0] REF_LO_OFS = 4'h8;
	localparam logic [3:0] REF_HI_OFS = 4'hc;
	// field positions
	localparam int CTRL_REF_LOAD_BIT = 0;
	localparam int STAT_THR_LSB = 8;
	localparam int STAT_FLAG_BIT = 16;
	localparam int STAT_INV_BIT = 17;
	localparam int STAT_HIZ_BIT = 18;
	// values after reset
	localparam logic CTRL_RST = 1'b0;
	localparam logic [6:0] SCORE_RST = 7'h00;
	localparam logic [6:0] THR_RST = 7'h00;
	// zero score meets zero threshold, so the flag starts high
	localparam logic FLAG_RST = 1'b1;
	localparam logic [63:0] VEC_RST = 64'h0;
endpackage : bcr_pkg

//--- verilog/bcr_pin_sync.sv
// two-flop synchroniser with rising edge detection for a pin group
`timescale 1ns/10ps
module bcr_pin_sync #(
	parameter int WIDTH = 17
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] pin_i,
	output logic [WIDTH-1:0] level_o,
	output logic [WIDTH-1:0] rise_o
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] prev_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] sync_next;
	logic [WIDTH-1:0] prev_next;

	// next values of the three stages
	always_comb begin
		meta_next = pin_i;
		sync_next = meta_reg;
		prev_next = sync_reg;
	end

	// stage registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_reg <= '0;
			sync_reg <= '0;
			prev_reg <= '0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
			prev_reg <= prev_next;
		end
	end

	// edge seen only on the settled stages
	assign level_o = sync_reg;
	assign rise_o = sync_reg & ~prev_reg;
endmodule : bcr_pin_sync

//--- tb/bcr_host_model.sv
// host-side pin driver model for the correlator
`timescale 1ns/10ps
module bcr_host_model (
	input wire logic clk_i,
	input wire logic [6:0] score_i,
	input wire logic oe_n_i,
	output logic [2:0] din_o,
	output logic [4:0] sclk_o,
	output logic ld_o,
	output logic hiz_o,
	output logic inv_o,
	output logic [6:0] bus_o
);
	logic drv = 1'b0;
	logic [6:0] thr_val = 7'h00;
	logic [6:0] last = 7'h00;
	// idle pin levels from time zero
	initial begin
		{din_o, sclk_o, ld_o, hiz_o, inv_o} = '0;
	end
	// resolved pin level, a released bus shows a toggling pattern
	assign bus_o = !oe_n_i ? score_i : (drv ? thr_val : ~last);
	always @(posedge clk_i) last <= bus_o;
	task automatic hold(input int n);
		repeat (n) @(posedge clk_i);
	endtask : hold
	// clocks 0..2 shift, 3 threshold, 4 summer; levels held 4 clocks
	task automatic pulse(input int w, input logic b);
		if (w < 3) din_o[w] <= b;
		hold(4);
		sclk_o[w] <= 1'b1;
		hold(4);
		sclk_o[w] <= 1'b0;
		hold(4);
	endtask : pulse
	// sample and summer clocks tied together for one shift
	task automatic tied(input logic b);
		din_o[0] <= b;
		hold(4);
		sclk_o[0] <= 1'b1;
		sclk_o[4] <= 1'b1;
		hold(4);
		sclk_o[0] <= 1'b0;
		sclk_o[4] <= 1'b0;
		hold(4);
	endtask : tied
	// whole word msb first, load raised in the last template cycle
	task automatic word(input int w, input logic [63:0] v, input logic ld);
		for (int i = 63; i >= 0; i--) begin
			if (ld && i == 0) ld_o <= 1'b1;
			pulse(w, v[i]);
		end
		ld_o <= 1'b0;
		hold(2);
	endtask : word
	// release the pins before driving a threshold
	task automatic thr(input logic [6:0] v);
		hiz_o <= 1'b1;
		hold(6);
		thr_val <= v;
		drv <= 1'b1;
		pulse(3, 1'b0);
		drv <= 1'b0;
		hiz_o <= 1'b0;
		hold(6);
	endtask : thr
	// invert changed only while summer clock is low
	task automatic output_invert_ctrl(input logic v);
		inv_o <= v;
		hold(4);
	endtask : output_invert_ctrl
endmodule : bcr_host_model

//--- tb/tb_binary_correlator_64.sv
// self-checking bench for the binary correlator
`timescale 1ns/10ps
module tb_binary_correlator_64;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
	logic [3:0] wb_adr = 4'h0;
	logic [31:0] wb_dat = 32'h0, rd, wb_dat_o;
	logic wb_ack_o, oe_n, flag, ld, hiz, output_invert_ctrl, nb;
	logic [2:0] din;
	logic [4:0] sck;
	logic [6:0] sc_o, sc_i;
	logic [63:0] a_m = 64'h0, t_m = 64'h0, m_m = 64'h0, r_m = 64'h0;
	int thr_m = 0, e0 = 0, error_cnt = 0, checks_done = 0, cyc_n = 0, seed = 43943;
	int tv[2];
	bcr_correlator i_bcr_correlator (.clk_i(clk_i), .rst_i(rst_i),
		.sample_din_i(din[0]), .template_din_i(din[1]), .mask_din_i(din[2]),
		.sample_clk_i(sck[0]), .template_clk_i(sck[1]), .mask_clk_i(sck[2]),
		.threshold_clk_i(sck[3]), .summer_clk_i(sck[4]), .reference_load_ctrl_i(ld),
		.output_hiz_ctrl_i(hiz), .output_invert_ctrl_i(output_invert_ctrl), .score_bus_i(sc_i),
		.score_bus_o(sc_o), .score_bus_oe_n_o(oe_n), .threshold_hit_flag_o(flag),
		.wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
	bcr_host_model i_bcr_host_model (.clk_i(clk_i), .score_i(sc_o), .oe_n_i(oe_n),
		.din_o(din), .sclk_o(sck), .ld_o(ld), .hiz_o(hiz), .inv_o(output_invert_ctrl), .bus_o(sc_i));
	// clock, timeout and released-pin watch
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc_n <= cyc_n + 1;
		if (hiz && i_bcr_host_model.drv) check("oe_n", oe_n, 1'b1);
		if (cyc_n == 30000) begin
			error_cnt++;
			close_out();
		end
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : close_out
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	// classic single wishbone cycle, read data left in rd
	task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20) error_cnt++;
		rd = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk_i);
	endtask : wb
	// reference model: agreeing unmasked positions
	function automatic int exp_sc();
		int n = 0;
		for (int i = 0; i < 64; i++) n += (a_m[i] ~^ r_m[i]) & m_m[i];
		return n;
	endfunction : exp_sc
	task automatic load(input int w, input logic [63:0] v, input logic l);
		i_bcr_host_model.word(w, v, l);
		if (w == 0) a_m = v; else if (w == 1) t_m = v; else m_m = v;
		if (l) r_m = t_m;
	endtask : load
	task automatic sum(input int n);
		repeat (n) i_bcr_host_model.pulse(4, 1'b0);
	endtask : sum
	task automatic check_out();
		int e;
		e = exp_sc();
		wb(1'b0, 4'h4, 32'h0);
		check("score", sc_o, 7'(e) ^ {7{output_invert_ctrl}});
		check("flag", flag, e >= thr_m);
		check("status", {rd[18:16], rd[14:8], rd[6:0]},
			{1'b0, output_invert_ctrl, e >= thr_m, 7'(thr_m), 7'(e)});
		check("oe_n", oe_n, 1'b0);
	endtask : check_out
	task automatic check_ref();
		wb(1'b0, 4'h8, 32'h0);
		check("ref_lo", rd, r_m[31:0]);
		wb(1'b0, 4'hc, 32'h0);
		check("ref_hi", rd, r_m[63:32]);
	endtask : check_ref
	// main sequence
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		check("score_rst", sc_o, 7'h00);
		check("flag_rst", flag, 1'b1);
		$display("test reset done");
		load(2, {$random(seed), $random(seed)}, 1'b0);
		load(1, {$random(seed), $random(seed)}, 1'b1);
		load(0, {$random(seed), $random(seed)}, 1'b0);
		sum(2);
		check("early", sc_o, 7'h00);
		sum(1);
		check_ref();
		check_out();
		$display("test correlate done");
		e0 = exp_sc();
		tv = '{e0 + 1, e0};
		foreach (tv[k]) begin
			i_bcr_host_model.thr(7'(tv[k]));
			sum(2);
			check("flag_old", flag, e0 >= thr_m);
			thr_m = tv[k];
			sum(1);
			check_out();
		end
		$display("test threshold done");
		load(1, ~t_m, 1'b0);
		sum(3);
		check_ref();
		check_out();
		wb(1'b1, 4'h0, 32'h1);
		wb(1'b0, 4'h0, 32'h0);
		check("ctrl", rd[0], 1'b1);
		r_m = t_m;
		wb(1'b1, 4'h0, 32'h0);
		sum(3);
		check_ref();
		check_out();
		$display("test reference done");
		i_bcr_host_model.output_invert_ctrl(1'b1);
		check("inv_hold", sc_o, 7'(exp_sc()));
		sum(1);
		check_out();
		i_bcr_host_model.output_invert_ctrl(1'b0);
		sum(1);
		check_out();
		$display("test invert done");
		nb = 1'($random(seed));
		i_bcr_host_model.tied(nb);
		a_m = {a_m[62:0], nb};
		sum(3);
		check_out();
		load(2, 64'h0, 1'b0);
		sum(3);
		check_out();
		wb(1'b0, 4'h2, 32'h0);
		check("unmapped", rd, 32'h0);
		$display("test mask done");
		close_out();
	end
endmodule : tb_binary_correlator_64
